// file: hdl/cfl_defines.vh
`ifndef CFL_DEFINES_VH
`define CFL_DEFINES_VH
// configuration write selectors
`define CFL_SEL_PAT0    4'h0
`define CFL_SEL_MSK0    4'h4
`define CFL_SEL_MODE    4'h8
`define CFL_SEL_CTL1    4'h9
`define CFL_SEL_BTA     4'ha
`define CFL_SEL_BTB     4'hb
// filter modes in filter_mode_reg bits 5:4
`define CFL_MODE_LSB    4
`define CFL_FM_SINGLE   2'h0
`define CFL_FM_DUAL     2'h1
`define CFL_FM_QUAD     2'h2
// rx_flag_reg bit positions
`define CFL_F_WAKE      7
`define CFL_F_RWRN      6
`define CFL_F_TWRN      5
`define CFL_F_RERR      4
`define CFL_F_TERR      3
`define CFL_F_BOFF      2
`define CFL_F_OVR       1
`define CFL_F_RXF       0
// reset values
`define CFL_RST_CFG     8'h00
`define CFL_RST_TXE     3'h7
// error counter limits
`define CFL_WARN_LIM    8'h60
`define CFL_PASV_LIM    8'h7f
`define CFL_BOFF_LIM    9'h0ff
// recessive bits needed to resynchronise
`define CFL_SYNC_BITS   4'hb
`endif

// file: hdl/cfl_core.v
`timescale 1ns/10ps
`include "cfl_defines.vh"
module cfl_core
(
  input  wire        clock,
  input  wire        rst_b,
  input  wire        cpu_stop,
  input  wire        soft_reset_bit,
  input  wire        sleep_req,
  input  wire        wakeup_irq_enable,
  input  wire        rx_irq_enable,
  input  wire [2:0]  tx_empty_irq_enable,
  input  wire [5:0]  err_irq_enable,
  input  wire        cfg_we,
  input  wire [3:0]  cfg_sel,
  input  wire [7:0]  cfg_wdata,
  input  wire [7:0]  rx_flag_clr,
  input  wire [2:0]  tx_flag_clr,
  input  wire [2:0]  tx_done,
  input  wire [2:0]  abort_req,
  input  wire        tx_busy,
  input  wire        rx_busy,
  input  wire        rx_id_valid,
  input  wire [31:0] rx_id,
  input  wire        rx_eof,
  input  wire [7:0]  rx_err_cnt,
  input  wire [8:0]  tx_err_cnt,
  input  wire        bit_tick,
  input  wire        can_rx,
  input  wire        core_tx,
  output reg         can_tx,
  output reg  [7:0]  rx_flag_reg,
  output reg  [2:0]  tx_buffer_empty_flag,
  output reg         filter_hit_index_hi,
  output reg         filter_hit_index_lo,
  output reg         fg_copy,
  output reg  [2:0]  tx_request,
  output reg  [2:0]  abort_grant,
  output reg         sleep_ack,
  output reg  [3:0]  can_mode,
  output reg         core_clk_en,
  output reg         reg_clk_en,
  output reg         on_bus,
  output reg         busoff_count_en,
  output reg  [7:0]  control_reg_one,
  output reg  [7:0]  bus_timing_reg_a,
  output reg  [7:0]  bus_timing_reg_b,
  output reg  [7:0]  filter_mode_reg,
  output reg         tx_irq,
  output reg         rx_irq,
  output reg         err_irq,
  output reg         wake_irq
);

// ==========================================
// state encodings
localparam ST_RUN   = 4'b0001;
localparam ST_DRAIN = 4'b0010;
localparam ST_SLEEP = 4'b0100;
localparam ST_SYNC  = 4'b1000;
localparam MD_NORM  = 4'b0001;
localparam MD_SLEEP = 4'b0010;
localparam MD_SRST  = 4'b0100;
localparam MD_PDWN  = 4'b1000;

// ==========================================
// masked byte compare
function m8;
  input [7:0] a;
  input [7:0] p;
  input [7:0] m;
  begin
    m8 = &((a ~^ p) | m);
  end
endfunction

reg  [31:0] pat_q;
reg  [31:0] msk_q;
reg  [3:0]  st_q;
reg  [3:0]  st_d;
reg  [3:0]  rcnt_q;
reg  [3:0]  rcnt_d;
reg         rx_s1_q;
reg         rx_s2_q;
reg         rx_s3_q;
reg         hit_q;
reg  [1:0]  idx_q;
reg         bg_full_q;
reg  [1:0]  bg_idx_q;
reg  [5:0]  cond_q;
reg  [7:0]  rset;
reg  [7:0]  rcond;
reg         hit_d;
reg  [1:0]  idx_d;
wire [3:0]  bm;
wire [3:0]  qm;
wire [1:0]  fmode;
wire        asleep;
wire        awake;
wire        idle;
wire        activity;
wire        acc_eof;
wire        direct;
wire        deferred;
wire [5:0]  cond;
wire        normal_m;
wire        ack_d;

// ==========================================
// configuration bank, locked while on-line
always @(posedge clock or negedge rst_b)
begin
  if (!rst_b)
  begin
    pat_q            <= {4{`CFL_RST_CFG}};
    msk_q            <= {4{`CFL_RST_CFG}};
    filter_mode_reg  <= `CFL_RST_CFG;
    control_reg_one  <= `CFL_RST_CFG;
    bus_timing_reg_a <= `CFL_RST_CFG;
    bus_timing_reg_b <= `CFL_RST_CFG;
  end
  else if (cfg_we && soft_reset_bit)
  begin
    case (cfg_sel)
      4'h0: pat_q[31:24] <= cfg_wdata;
      4'h1: pat_q[23:16] <= cfg_wdata;
      4'h2: pat_q[15:8]  <= cfg_wdata;
      4'h3: pat_q[7:0]   <= cfg_wdata;
      4'h4: msk_q[31:24] <= cfg_wdata;
      4'h5: msk_q[23:16] <= cfg_wdata;
      4'h6: msk_q[15:8]  <= cfg_wdata;
      4'h7: msk_q[7:0]   <= cfg_wdata;
      `CFL_SEL_MODE: filter_mode_reg  <= cfg_wdata;
      `CFL_SEL_CTL1: control_reg_one  <= cfg_wdata;
      `CFL_SEL_BTA:  bus_timing_reg_a <= cfg_wdata;
      `CFL_SEL_BTB:  bus_timing_reg_b <= cfg_wdata;
      default: ;
    endcase
  end
end

// ==========================================
// acceptance filter
genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1)
  begin : g_flt
    // bm: byte k of id against byte k of bank
    assign bm[gi] = m8(rx_id[31-8*gi -: 8], pat_q[31-8*gi -: 8],
                       msk_q[31-8*gi -: 8]);
    // qm: first id byte against bank byte k
    assign qm[gi] = m8(rx_id[31:24], pat_q[31-8*gi -: 8],
                       msk_q[31-8*gi -: 8]);
  end
endgenerate

assign fmode = filter_mode_reg[`CFL_MODE_LSB +: 2];

always @*
begin
  hit_d = 1'b0;
  idx_d = 2'h0;
  case (fmode)
    `CFL_FM_SINGLE:
    begin
      hit_d = &bm;
    end
    `CFL_FM_DUAL:
    begin
      // filter 0 uses bank bytes 0-1, filter 1 bytes 2-3
      hit_d = (bm[0] & bm[1]) |
              (m8(rx_id[31:24], pat_q[15:8], msk_q[15:8]) &
               m8(rx_id[23:16], pat_q[7:0], msk_q[7:0]));
      idx_d = (bm[0] & bm[1]) ? 2'h0 : 2'h1;
    end
    `CFL_FM_QUAD:
    begin
      hit_d = |qm;
      idx_d = qm[0] ? 2'h0 : qm[1] ? 2'h1 :
              qm[2] ? 2'h2 : 2'h3;
    end
    default:
    begin
      hit_d = 1'b0;
    end
  endcase
end

// ==========================================
// pin sync and sleep sequencing
assign asleep   = (st_q == ST_SLEEP);
assign awake    = ~asleep & ~cpu_stop & ~soft_reset_bit;
assign idle     = ~tx_busy & ~rx_busy & (&tx_buffer_empty_flag);
assign activity = rx_s3_q & ~rx_s2_q;

always @*
begin
  st_d   = st_q;
  rcnt_d = rcnt_q;
  case (st_q)
    ST_RUN:
    begin
      if (sleep_req && !soft_reset_bit)
        st_d = idle ? ST_SLEEP : ST_DRAIN;
    end
    ST_DRAIN:
    begin
      if (!sleep_req || soft_reset_bit)
        st_d = ST_RUN;
      else if (idle)
        st_d = ST_SLEEP;
    end
    ST_SLEEP:
    begin
      if (activity || !sleep_req || soft_reset_bit)
        st_d = ST_SYNC;
      rcnt_d = 4'h0;
    end
    ST_SYNC:
    begin
      if (soft_reset_bit || !rx_s2_q)
        rcnt_d = 4'h0;
      else if (bit_tick)
        rcnt_d = rcnt_q + 4'h1;
      if (rcnt_q == `CFL_SYNC_BITS)
        st_d = ST_RUN;
    end
    default:
    begin
      st_d = ST_SYNC;
    end
  endcase
end

always @(posedge clock or negedge rst_b)
begin
  if (!rst_b)
  begin
    rx_s1_q <= 1'b1;
    rx_s2_q <= 1'b1;
    rx_s3_q <= 1'b1;
    st_q    <= ST_SYNC;
    rcnt_q  <= 4'h0;
  end
  else
  begin
    rx_s1_q <= can_rx;
    rx_s2_q <= rx_s1_q;
    rx_s3_q <= rx_s2_q;
    st_q    <= st_d;
    rcnt_q  <= rcnt_d;
  end
end

// ==========================================
// receive buffering
// frames ending outside ST_RUN are never accepted; while not awake the first accepted one waits in the background buffer
assign acc_eof  = rx_eof & hit_q & (st_q == ST_RUN);
assign direct   = acc_eof & ~rx_flag_reg[`CFL_F_RXF] & ~bg_full_q & awake;
assign deferred = bg_full_q & ~rx_flag_reg[`CFL_F_RXF] & awake;

always @(posedge clock or negedge rst_b)
begin
  if (!rst_b)
  begin
    hit_q     <= 1'b0;
    idx_q     <= 2'h0;
    bg_full_q <= 1'b0;
    bg_idx_q  <= 2'h0;
  end
  else
  begin
    if (rx_id_valid)
    begin
      hit_q <= hit_d;
      idx_q <= idx_d;
    end
    else if (rx_eof)
      hit_q <= 1'b0;
    if (deferred)
      bg_full_q <= 1'b0;
    else if (acc_eof && !direct && !bg_full_q)
    begin
      bg_full_q <= 1'b1;
      bg_idx_q  <= idx_q;
    end
  end
end

// ==========================================
// flags
assign cond[5] = (rx_err_cnt >= `CFL_WARN_LIM);
assign cond[4] = ({1'b0, tx_err_cnt} >= {2'h0, `CFL_WARN_LIM});
assign cond[3] = (rx_err_cnt > `CFL_PASV_LIM);
assign cond[2] = ({1'b0, tx_err_cnt} > {2'h0, `CFL_PASV_LIM});
assign cond[1] = (tx_err_cnt > `CFL_BOFF_LIM);
assign cond[0] = 1'b0;

always @*
begin
  rset  = {1'b0, cond[5:1] & ~cond_q[5:1], 2'h0};
  rcond = {1'b0, cond[5:1], 2'h0};
  rset[`CFL_F_WAKE] = activity & sleep_ack & wakeup_irq_enable;
  rset[`CFL_F_OVR]  = acc_eof & rx_flag_reg[`CFL_F_RXF] & bg_full_q;
  rset[`CFL_F_RXF]  = direct | deferred;
end

assign normal_m = awake & (st_q == ST_RUN);
// mode and clock enable follow the next ack so they never lag the flag
assign ack_d    = (st_d == ST_SLEEP);

always @(posedge clock or negedge rst_b)
begin
  if (!rst_b)
  begin
    cond_q               <= 6'h00;
    rx_flag_reg          <= 8'h00;
    tx_buffer_empty_flag <= `CFL_RST_TXE;
    filter_hit_index_hi  <= 1'b0;
    filter_hit_index_lo  <= 1'b0;
    fg_copy              <= 1'b0;
  end
  else
  begin
    cond_q      <= cond;
    // set wins, clear needs 1 and, for bits 6:2, a gone cause
    rx_flag_reg <= rset | (rx_flag_reg & ~(rx_flag_clr & ~rcond));
    tx_buffer_empty_flag <= tx_done |
      (tx_buffer_empty_flag & ~tx_flag_clr);
    fg_copy     <= rset[`CFL_F_RXF];
    if (rset[`CFL_F_RXF])
    begin
      filter_hit_index_hi <= deferred ? bg_idx_q[1] : idx_q[1];
      filter_hit_index_lo <= deferred ? bg_idx_q[0] : idx_q[0];
    end
  end
end

// ==========================================
// mode, pins and interrupt outputs
always @(posedge clock or negedge rst_b)
begin
  if (!rst_b)
  begin
    can_tx          <= 1'b1;
    sleep_ack       <= 1'b0;
    can_mode        <= MD_SRST;
    core_clk_en     <= 1'b0;
    reg_clk_en      <= 1'b0;
    on_bus          <= 1'b0;
    busoff_count_en <= 1'b0;
    tx_request      <= 3'h0;
    abort_grant     <= 3'h0;
    tx_irq          <= 1'b0;
    rx_irq          <= 1'b0;
    err_irq         <= 1'b0;
    wake_irq        <= 1'b0;
  end
  else
  begin
    sleep_ack <= ack_d;
    if (cpu_stop)
      can_mode <= MD_PDWN;
    else if (ack_d && !soft_reset_bit)
      can_mode <= MD_SLEEP;
    else if (soft_reset_bit && !ack_d)
      can_mode <= MD_SRST;
    else
      can_mode <= MD_NORM;
    // clock enables stand in for gated clocks
    core_clk_en <= ~cpu_stop & ~ack_d & ~soft_reset_bit;
    reg_clk_en  <= ~cpu_stop;
    on_bus      <= normal_m;
    can_tx      <= normal_m ? core_tx : 1'b1;
    // recovery counter runs only while awake, so it stops one cycle after core_clk_en on sleep entry
    busoff_count_en <= cond[1] & awake;
    tx_request  <= normal_m ? ~tx_buffer_empty_flag : 3'h0;
    abort_grant <= normal_m ?
      (abort_req & ~tx_buffer_empty_flag) : 3'h0;
    tx_irq   <= |(tx_buffer_empty_flag & tx_empty_irq_enable);
    rx_irq   <= rx_flag_reg[`CFL_F_RXF] & rx_irq_enable;
    err_irq  <= |(rx_flag_reg[6:1] & err_irq_enable);
    wake_irq <= rx_flag_reg[`CFL_F_WAKE];
  end
end

// error counters enter only as inputs, never written here
endmodule

// file: test/cfl_bus_node.sv
`timescale 1ns/10ps
module cfl_bus_node (
  input  wire clock,
  input  wire can_tx,
  input  wire send,
  output wire can_rx
);
  reg [3:0] dom_q = 4'h0;
  // ====================
  // wired-and bus
  // a released bus floats recessive, so only a dominant can_tx or an explicit send pulls it low
  assign can_rx = can_tx & (dom_q == 4'h0);
  always @(posedge clock)
    if (send)
      dom_q <= 4'hf;
    else if (dom_q != 4'h0)
      dom_q <= dom_q - 4'h1;
endmodule

// file: test/cfl_core_sva.sv
`timescale 1ns/10ps
module cfl_core_sva (
  input wire       clock,
  input wire       rst_b,
  input wire       cpu_stop,
  input wire       soft_reset_bit,
  input wire       rx_irq_enable,
  input wire       wakeup_irq_enable,
  input wire [2:0] tx_empty_irq_enable,
  input wire [7:0] rx_err_cnt,
  input wire [8:0] tx_err_cnt,
  input wire       can_tx,
  input wire [7:0] rx_flag_reg,
  input wire [2:0] tx_buffer_empty_flag,
  input wire       sleep_ack,
  input wire [3:0] can_mode,
  input wire [7:0] filter_mode_reg,
  input wire [7:0] control_reg_one,
  input wire       tx_irq,
  input wire       rx_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ====================
  // assertions
  a_tx_recessive: assert property (!can_mode[0] && !$past(can_mode[0]) |-> can_tx)
    else $error("dominant output outside normal mode");
  a_pd_mode: assert property (cpu_stop |=> can_mode == 4'h8)
    else $error("no power-down with cpu stopped");
  a_cfg_lock: assert property (!soft_reset_bit |=> $stable(filter_mode_reg) && $stable(control_reg_one))
    else $error("config changed while locked");
  a_warn_flag: assert property (rx_err_cnt >= 8'h60 && $past(rx_err_cnt) < 8'h60 |=> rx_flag_reg[6])
    else $error("rx warning not flagged");
  a_busoff_flag: assert property (tx_err_cnt > 9'h0ff |=> rx_flag_reg[2])
    else $error("bus-off not flagged");
  a_ack_sleep: assert property (sleep_ack && !can_mode[3] |-> can_mode[1])
    else $error("ack without sleep mode");
  a_wake_cause: assert property ($rose(rx_flag_reg[7]) |-> $past(sleep_ack) && $past(wakeup_irq_enable))
    else $error("wake flag without ack and enable");
  a_rx_irq: assert property ($rose(rx_flag_reg[0]) && rx_irq_enable |=> rx_irq)
    else $error("rx irq missing");
  a_tx_irq: assert property (|(tx_buffer_empty_flag & tx_empty_irq_enable) |=> tx_irq)
    else $error("tx irq missing");
  c_sleep: cover property ($rose(sleep_ack));
  c_rxf: cover property ($rose(rx_flag_reg[0]));
  c_boff: cover property ($rose(rx_flag_reg[2]));
endmodule
bind cfl_core cfl_core_sva u_sva (.clock, .rst_b, .cpu_stop, .soft_reset_bit, .rx_irq_enable, .wakeup_irq_enable,
  .tx_empty_irq_enable, .rx_err_cnt, .tx_err_cnt, .can_tx, .rx_flag_reg, .tx_buffer_empty_flag, .sleep_ack,
  .can_mode, .filter_mode_reg, .control_reg_one, .tx_irq, .rx_irq);

// file: test/tb_cfl_core.sv
`timescale 1ns/10ps
module tb_cfl_core;
  reg         clock, rst_b, cpu_stop, soft_reset_bit, sleep_req, wakeup_irq_enable, rx_irq_enable;
  reg         cfg_we, tx_busy, rx_busy, rx_id_valid, rx_eof, bit_tick, core_tx, send;
  reg  [2:0]  tx_empty_irq_enable, tx_flag_clr, tx_done, abort_req;
  reg  [5:0]  err_irq_enable;
  reg  [3:0]  cfg_sel;
  reg  [7:0]  cfg_wdata, rx_flag_clr, rx_err_cnt;
  reg  [8:0]  tx_err_cnt;
  reg  [31:0] rx_id;
  wire        can_rx, can_tx, filter_hit_index_hi, filter_hit_index_lo, sleep_ack, core_clk_en, reg_clk_en;
  wire        on_bus, tx_irq, rx_irq, err_irq, fg_copy, busoff_count_en, wake_irq;
  wire [2:0]  abort_grant;
  wire [7:0]  control_reg_one, bus_timing_reg_a, bus_timing_reg_b;
  wire [7:0]  rx_flag_reg, filter_mode_reg;
  wire [2:0]  tx_buffer_empty_flag, tx_request;
  wire [3:0]  can_mode;
  integer     num_errors, n_tests;
  cfl_core dut (.clock, .rst_b, .cpu_stop, .soft_reset_bit, .sleep_req, .wakeup_irq_enable, .rx_irq_enable,
    .tx_empty_irq_enable, .err_irq_enable, .cfg_we, .cfg_sel, .cfg_wdata, .rx_flag_clr, .tx_flag_clr, .tx_done,
    .abort_req, .tx_busy, .rx_busy, .rx_id_valid, .rx_id, .rx_eof, .rx_err_cnt, .tx_err_cnt, .bit_tick, .can_rx,
    .core_tx, .can_tx, .rx_flag_reg, .tx_buffer_empty_flag, .filter_hit_index_hi, .filter_hit_index_lo,
    .fg_copy, .tx_request, .abort_grant, .sleep_ack, .can_mode, .core_clk_en, .reg_clk_en, .on_bus,
    .busoff_count_en, .control_reg_one, .bus_timing_reg_a, .bus_timing_reg_b, .filter_mode_reg,
    .tx_irq, .rx_irq, .err_irq, .wake_irq);
  cfl_bus_node node (.clock, .can_tx, .send, .can_rx);
  // ====================
  // helpers
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    bit_tick = 1'b0;
    forever
    begin
      repeat (3) @(negedge clock);
      bit_tick = 1'b1;
      @(negedge clock);
      bit_tick = 1'b0;
    end
  end
  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // 0 on_bus, 1 sleep_ack, 2 wake flag
  task wt(input [1:0] k);
    integer i;
    i = 0;
    while (i < 300 && (k == 0 ? on_bus : k == 1 ? sleep_ack : rx_flag_reg[7]) !== 1'b1)
    begin
      i = i + 1;
      cyc(1);
    end
    if (i == 300)
    begin
      num_errors = num_errors + 1;
      final_report;
    end
  endtask
  task wr(input [3:0] s, input [7:0] d);
    cfg_sel = s;
    cfg_wdata = d;
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    // let an edge pass so back-to-back writes never retoggle the strobe at once
    cyc(1);
  endtask
  // write-one-clear with only the wanted bits, never a read-modify-write
  task clr(input [7:0] m);
    rx_flag_clr = m;
    cyc(1);
    rx_flag_clr = 8'h00;
    cyc(2);
  endtask
  task txc(input [2:0] c, input [2:0] d);
    tx_flag_clr = c;
    tx_done = d;
    cyc(1);
    {tx_flag_clr, tx_done} = 6'h00;
    cyc(2);
  endtask
  task frame(input [31:0] id, input c);
    rx_id = id;
    rx_id_valid = 1'b1;
    cyc(1);
    rx_id_valid = 1'b0;
    cyc(2);
    rx_eof = 1'b1;
    cyc(1);
    rx_eof = 1'b0;
    chk(fg_copy, c);
    cyc(2);
  endtask
  // ====================
  // scenarios
  task t_lock;
    integer k;
    reg [63:0] bank;
    bank = 64'h11223322_00000f00;
    wr(4'h8, 8'h20);
    chk(filter_mode_reg, 8'h00);
    soft_reset_bit = 1'b1;
    cyc(2);
    chk({can_mode, core_clk_en, reg_clk_en, can_tx}, 7'h23);
    for (k = 0; k < 8; k = k + 1)
      wr(k[3:0], bank[63 - 8 * k -: 8]);
    wr(4'h8, 8'h20);
    chk(filter_mode_reg, 8'h20);
    wr(4'h9, 8'h5a);
    wr(4'ha, 8'h3c);
    wr(4'hb, 8'hc3);
    chk({control_reg_one, bus_timing_reg_a, bus_timing_reg_b}, 24'h5a3cc3);
    soft_reset_bit = 1'b0;
    wt(0);
    wr(4'h9, 8'hff);
    chk(control_reg_one, 8'h5a);
  endtask
  task t_filter;
    frame(32'h22000000, 1'b1);
    chk({rx_flag_reg[0], filter_hit_index_hi, filter_hit_index_lo, rx_irq}, 4'hb);
    clr(8'h01);
    frame(32'h3a000000, 1'b1);
    chk({rx_flag_reg[0], filter_hit_index_hi, filter_hit_index_lo}, 3'h6);
    frame(32'h22000000, 1'b0);
    frame(32'h22000000, 1'b0);
    chk(rx_flag_reg[1], 1'b1);
    clr(8'h01);
    chk({rx_flag_reg[0], filter_hit_index_hi, filter_hit_index_lo}, 3'h5);
    clr(8'h03);
    frame(32'h55000000, 1'b0);
    chk(rx_flag_reg[1:0], 2'h0);
  endtask
  task t_tx;
    tx_empty_irq_enable = 3'h1;
    cyc(2);
    chk(tx_irq, 1'b1);
    txc(3'h1, 3'h0);
    chk({tx_buffer_empty_flag, tx_request, tx_irq}, 7'h62);
    txc(3'h0, 3'h1);
    chk(tx_buffer_empty_flag, 3'h7);
  endtask
  task t_sleep;
    rx_busy = 1'b1;
    sleep_req = 1'b1;
    cyc(6);
    chk(sleep_ack, 1'b0);
    rx_busy = 1'b0;
    wt(1);
    core_tx = 1'b0;
    wakeup_irq_enable = 1'b1;
    abort_req = 3'h2;
    txc(3'h2, 3'h0);
    chk({can_mode, can_tx, tx_request, abort_grant}, 11'h140);
    send = 1'b1;
    cyc(1);
    send = 1'b0;
    wt(2);
    cyc(1);
    chk(wake_irq, 1'b1);
    sleep_req = 1'b0;
    core_tx = 1'b1;
    chk({sleep_ack, on_bus}, 2'h0);
    clr(8'h80);
    wt(0);
    cyc(2);
    chk({tx_request, abort_grant}, 6'h12);
    abort_req = 3'h0;
    txc(3'h0, 3'h2);
  endtask
  task t_pd;
    cpu_stop = 1'b1;
    cyc(2);
    chk({can_mode, core_clk_en, reg_clk_en}, 6'h20);
    cpu_stop = 1'b0;
    wt(0);
  endtask
  task t_err;
    rx_err_cnt = 8'h60;
    cyc(3);
    chk({rx_flag_reg[6], err_irq}, 2'h3);
    clr(8'h40);
    chk(rx_flag_reg[6], 1'b1);
    rx_err_cnt = 8'h00;
    clr(8'h40);
    chk(rx_flag_reg[6], 1'b0);
    tx_err_cnt = 9'h080;
    cyc(3);
    chk(rx_flag_reg[5:2], 4'ha);
    tx_err_cnt = 9'h100;
    cyc(3);
    chk(rx_flag_reg[2], 1'b1);
    chk(busoff_count_en, 1'b1);
    sleep_req = 1'b1;
    wt(1);
    cyc(2);
    chk(busoff_count_en, 1'b0);
    sleep_req = 1'b0;
    wt(0);
    chk(busoff_count_en, 1'b1);
  endtask
  // ====================
  // main sequence
  initial
  begin
    num_errors = 0;
    n_tests = 0;
    {cpu_stop, soft_reset_bit, sleep_req, wakeup_irq_enable, cfg_we, tx_busy, rx_busy, rx_id_valid, rx_eof,
      send, tx_empty_irq_enable, tx_flag_clr, tx_done, abort_req, cfg_sel, cfg_wdata, rx_flag_clr,
      rx_err_cnt, tx_err_cnt, rx_id} = 0;
    {core_tx, rx_irq_enable, err_irq_enable} = 8'hff;
    rst_b = 1'b0;
    cyc(20);
    chk({can_mode, tx_buffer_empty_flag, can_tx}, 8'h4f);
    rst_b = 1'b1;
    t_lock;
    t_filter;
    t_tx;
    t_sleep;
    t_pd;
    t_err;
    final_report;
  end
endmodule
